// ---- logic/flash_read_pkg.sv ----
// shared constants for the burst flash read controller
package flash_read_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int STEP_W  = 4;              // width of the edge counter
    localparam int BADDR_W = 2;              // burst counter width (a3-a2)

    // ****************************************************************
    // edge numbers of the default-latency sequence
    // ****************************************************************
    localparam logic [3:0] N_START        = 4'h1; // edge that takes the cycle
    localparam logic [3:0] DEF_OE_N       = 4'h3; // output enable goes low
    localparam logic [3:0] DEF_KEN_N      = 4'h4; // cacheable ahead of ready
    localparam logic [3:0] DEF_BURST_READY_N     = 4'h5; // first ready driven low
    localparam logic [3:0] DEF_ADV_END_N  = 4'h8; // address valid pulses end
    localparam logic [3:0] DEF_STEP_MIN_N = 4'h3; // first counter advance

    // ****************************************************************
    // edge numbers of the optimized-latency sequence
    // ****************************************************************
    localparam logic [3:0] OPT_OE_N      = 4'h2; // output enable goes low
    localparam logic [3:0] OPT_KEN_N     = 4'h2; // cache enable goes low
    localparam logic [3:0] OPT_BURST_READY_N    = 4'h3; // ready driven low, held
    localparam logic [3:0] OPT_ADV_END_N = 4'h4; // address valid rises here

    // ****************************************************************
    // flash latency settings the two sequences are built for
    // ****************************************************************
    localparam int DEF_LATENCY_SETTING = 4;
    localparam int OPT_LATENCY_SETTING = 2;

    // ****************************************************************
    // reset values of the outputs (pins are active low unless noted)
    // ****************************************************************
    localparam logic RST_ADV_B  = 1'b0; // address valid held active
    localparam logic RST_PATH   = 1'b1; // processor drives low address
    localparam logic RST_OE_B   = 1'b1; // flash outputs off
    localparam logic RST_CE_B   = 1'b0; // chip enable held active
    localparam logic RST_BURST_READY_B = 1'b1; // no ready
    localparam logic RST_KEN_B  = 1'b1; // not cacheable
    localparam logic RST_CFG    = 1'b0; // default latency after reset
    localparam logic [1:0] RST_BADDR = 2'h0; // burst counter cleared
    localparam logic [3:0] RST_STEP  = 4'h0; // edge counter cleared

    // ****************************************************************
    // read machine states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,      // anticipation: waiting for a bus cycle
        ST_DEF_READ,  // default-latency burst in progress
        ST_OPT_READ   // optimized-latency burst in progress
    } rd_state_t;

endpackage : flash_read_pkg

// ---- logic/burst_addr_counter.sv ----
// two-bit interleaved burst address counter
`timescale 1ns/1ps
module burst_addr_counter #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    // control
    input  wire logic         load_in,
    input  wire logic         step_in,
    input  wire logic [W-1:0] start_in,
    // flash low address
    output logic      [W-1:0] addr_out
);
    logic [W-1:0] start_q;   // first address of the burst
    logic [W-1:0] count_q;   // transfers issued past the first
    logic [W-1:0] count_d;

    // ****************************************************************
    // step count
    // ****************************************************************
    // load already counts one: the processor gave the first address
    always_comb begin
        count_d = count_q;
        if (load_in) begin
            count_d = {{(W-1){1'b0}}, 1'b1};
        end else if (step_in) begin
            count_d = count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // start address kept so the order is derived, not tabled
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            start_q <= '0;
            count_q <= '0;
        end else begin
            if (load_in) begin
                start_q <= start_in;
            end
            count_q <= count_d;
        end
    end

    // interleaved order is the start xor the step count
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            addr_out <= '0;
        end else if (load_in) begin
            addr_out <= start_in ^ count_d;
        end else begin
            addr_out <= start_q ^ count_d;
        end
    end

endmodule : burst_addr_counter

// ---- logic/burst_flash_read_control.sv ----
// read-control machine bridging a burst cpu bus to burst flash
`timescale 1ns/1ps

module burst_flash_read_control
    import flash_read_pkg::*;
#(
    parameter int BADDR_BITS = flash_read_pkg::BADDR_W
) (
    // clock and reset
    input  wire logic                  CLK_IN,
    input  wire logic                  RST_B_IN,
    // processor bus cycle signals
    input  wire logic                  ADDRESS_STROBE_B_IN,
    input  wire logic                  WRITE_READ_SELECT_IN,
    input  wire logic                  BACKOFF_REQUEST_B_IN,
    input  wire logic                  BURST_LAST_B_IN,
    input  wire logic [BADDR_BITS-1:0] CPU_ADDR_IN,
    // address decode
    input  wire logic                  FLASH_REGION_SELECT_IN,
    // latency configuration from a general purpose pin
    input  wire logic                  CONFIG_SELECT_IN,
    // answers to the processor
    output logic                       BURST_READY_B_OUT,
    output logic                       CACHE_ENABLE_ACK_B_OUT,
    // flash control
    output logic                       FLASH_ADDRESS_VALID_B_OUT,
    output logic                       FLASH_OUTPUT_ENABLE_B_OUT,
    output logic                       FLASH_CHIP_ENABLE_B_OUT,
    output logic                       ADDRESS_PATH_SELECT_OUT,
    output logic [BADDR_BITS-1:0]      BURST_ADDR_OUT
);
    import flash_read_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    rd_state_t           state_q;       // read machine state
    rd_state_t           state_d;       // its next value
    logic [STEP_W-1:0]   n_q;           // number of the last edge
    logic [STEP_W-1:0]   n_d;           // its next value
    logic [STEP_W-1:0]   nxt;           // number of the coming edge
    logic                cfg_meta_q;    // config sync, first stage
    logic                cfg_q;         // config sync, second stage
    logic                adv_b_q;       // address valid register
    logic                adv_b_d;
    logic                oe_b_q;        // output enable register
    logic                oe_b_d;
    logic                ce_b_q;        // chip enable register
    logic                burst_ready_b_q;      // burst ready register
    logic                burst_ready_b_d;
    logic                ken_b_q;       // cache enable register
    logic                ken_b_d;
    logic                path_q;        // 1: processor drives a3-a2
    logic                path_d;
    logic                in_read;       // a burst is running
    logic                backoff;       // backoff seen this edge
    logic                start;         // flash read taken this edge
    logic                burst_done;    // terminating ready this edge
    logic                leave;         // return to idle this edge
    logic                cnt_load;      // load burst counter
    logic                cnt_step;      // advance burst counter

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // default sequence: address valid low ahead of edges 3, 5, 7
    function automatic logic def_adv_low(input logic [STEP_W-1:0] e);
        def_adv_low = (e[0] == 1'b0) && (e < DEF_ADV_END_N);
    endfunction : def_adv_low

    // default sequence: counter moves on edges 3 and 5
    function automatic logic def_step(input logic [STEP_W-1:0] e);
        def_step = (e[0] == 1'b1) && (e >= DEF_STEP_MIN_N)
                   && (e < DEF_ADV_END_N - 4'h1);
    endfunction : def_step

    // ****************************************************************
    // configuration input synchroniser
    // ****************************************************************
    // the pin is set by software at any time, so it is resynchronised;
    // its value only matters at the start of a cycle
    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            cfg_meta_q <= RST_CFG;
            cfg_q      <= RST_CFG;
        end else begin
            cfg_meta_q <= CONFIG_SELECT_IN;
            cfg_q      <= cfg_meta_q;
        end
    end

    // ****************************************************************
    // cycle events
    // ****************************************************************
    // processor pins share our clock, so they are sampled directly
    always_comb begin
        in_read = (state_q != ST_IDLE);
        // backoff is the only abort, in either configuration
        backoff = !BACKOFF_REQUEST_B_IN;
        // read strobe with the flash region decoded
        start   = (state_q == ST_IDLE) && !backoff
                  && !ADDRESS_STROBE_B_IN
                  && !WRITE_READ_SELECT_IN
                  && !FLASH_REGION_SELECT_IN;
        // ready being sampled low together with the last flag
        burst_done = in_read && !burst_ready_b_q
                     && !BURST_LAST_B_IN;
        leave   = in_read && (backoff || burst_done);
    end

    // saturating count so a long burst never wraps the decode
    always_comb begin
        if (n_q == {STEP_W{1'b1}}) begin
            nxt = n_q;
        end else begin
            nxt = n_q + 4'h1;
        end
    end

    // ****************************************************************
    // read state machine
    // ****************************************************************
    // a cycle outside the flash region is simply never entered, so the
    // machine stays in the anticipation state for the next strobe
    always_comb begin
        state_d = state_q;
        n_d     = n_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    // configuration picked once, at entry
                    if (cfg_q) begin
                        state_d = ST_OPT_READ;
                    end else begin
                        state_d = ST_DEF_READ;
                    end
                    n_d = N_START;
                end
            end
            ST_DEF_READ, ST_OPT_READ: begin
                if (leave) begin
                    state_d = ST_IDLE;
                    n_d     = RST_STEP;
                end else begin
                    n_d = nxt;
                end
            end
            default: begin
                state_d = ST_IDLE;
                n_d     = RST_STEP;
            end
        endcase
    end

    // state and edge counter
    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            state_q <= ST_IDLE;
            n_q     <= RST_STEP;
        end else begin
            state_q <= state_d;
            n_q     <= n_d;
        end
    end

    // ****************************************************************
    // flash address valid
    // ****************************************************************
    // the first access is launched by the valid held in idle together
    // with the processor's own address on the start edge
    always_comb begin
        adv_b_d = RST_ADV_B;
        case (state_q)
            ST_IDLE: begin
                if (start && !cfg_q) begin
                    adv_b_d = 1'b1;
                end else begin
                    adv_b_d = RST_ADV_B;
                end
            end
            ST_DEF_READ: begin
                if (leave) begin
                    adv_b_d = RST_ADV_B;
                end else begin
                    // one access every other edge, none after eight
                    adv_b_d = !def_adv_low(nxt);
                end
            end
            ST_OPT_READ: begin
                if (leave) begin
                    adv_b_d = RST_ADV_B;
                end else begin
                    // low for three clocks, then released
                    adv_b_d = (nxt >= OPT_ADV_END_N);
                end
            end
            default: begin
                adv_b_d = RST_ADV_B;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            adv_b_q <= RST_ADV_B;
        end else begin
            adv_b_q <= adv_b_d;
        end
    end

    // ****************************************************************
    // burst address counter and path select
    // ****************************************************************
    // the counter takes over after the first address, so it is loaded
    // already one step ahead
    always_comb begin
        cnt_load = start;
        cnt_step = 1'b0;
        if (state_q == ST_DEF_READ && !leave) begin
            cnt_step = def_step(nxt);
        end else if (state_q == ST_OPT_READ && !leave) begin
            cnt_step = (nxt < OPT_ADV_END_N);
        end
    end

    burst_addr_counter #(
        .W        (BADDR_BITS)
    ) u_burst_cnt (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .load_in  (cnt_load),
        .step_in  (cnt_step),
        .start_in (CPU_ADDR_IN),
        .addr_out (BURST_ADDR_OUT)
    );

    // path follows the counter for the rest of the burst
    always_comb begin
        path_d = path_q;
        if (start) begin
            path_d = 1'b0;
        end else if (leave) begin
            path_d = RST_PATH;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            path_q <= RST_PATH;
        end else begin
            path_q <= path_d;
        end
    end

    // ****************************************************************
    // flash output and chip enables
    // ****************************************************************
    // backoff turns the outputs off on the edge it is seen, since the
    // processor may already be floating the bus for another master
    always_comb begin
        oe_b_d = oe_b_q;
        if (!in_read) begin
            oe_b_d = RST_OE_B;
        end else if (leave) begin
            oe_b_d = 1'b1;
        end else if (state_q == ST_DEF_READ && nxt == DEF_OE_N) begin
            oe_b_d = 1'b0;
        end else if (state_q == ST_OPT_READ && nxt == OPT_OE_N) begin
            oe_b_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            oe_b_q <= RST_OE_B;
        end else begin
            oe_b_q <= oe_b_d;
        end
    end

    // chip enable never drops: keeps the enable setup met for the first
    // access and the data hold after output enable; costs idle power
    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            ce_b_q <= RST_CE_B;
        end else begin
            ce_b_q <= RST_CE_B;
        end
    end

    // ****************************************************************
    // burst ready
    // ****************************************************************
    // default: ready toggles so each word gets two edges of latency;
    // optimized: ready stays low and one word moves per edge
    always_comb begin
        burst_ready_b_d = burst_ready_b_q;
        if (!in_read || leave) begin
            burst_ready_b_d = RST_BURST_READY_B;
        end else if (state_q == ST_DEF_READ) begin
            if (nxt == DEF_BURST_READY_N) begin
                burst_ready_b_d = 1'b0;
            end else if (nxt > DEF_BURST_READY_N) begin
                burst_ready_b_d = !burst_ready_b_q;
            end
        end else if (state_q == ST_OPT_READ) begin
            if (nxt == OPT_BURST_READY_N) begin
                burst_ready_b_d = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            burst_ready_b_q <= RST_BURST_READY_B;
        end else begin
            burst_ready_b_q <= burst_ready_b_d;
        end
    end

    // ****************************************************************
    // cache enable
    // ****************************************************************
    // must be seen one clock before the first ready and through the
    // last, so it is held to the end of the burst
    always_comb begin
        ken_b_d = ken_b_q;
        if (!in_read || leave) begin
            ken_b_d = RST_KEN_B;
        end else if (state_q == ST_DEF_READ && nxt == DEF_KEN_N) begin
            ken_b_d = 1'b0;
        end else if (state_q == ST_OPT_READ && nxt == OPT_KEN_N) begin
            ken_b_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            ken_b_q <= RST_KEN_B;
        end else begin
            ken_b_q <= ken_b_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // all pins come straight from the registers above
    assign BURST_READY_B_OUT         = burst_ready_b_q;
    assign CACHE_ENABLE_ACK_B_OUT    = ken_b_q;
    assign FLASH_ADDRESS_VALID_B_OUT = adv_b_q;
    assign FLASH_OUTPUT_ENABLE_B_OUT = oe_b_q;
    assign FLASH_CHIP_ENABLE_B_OUT   = ce_b_q;
    assign ADDRESS_PATH_SELECT_OUT   = path_q;

endmodule : burst_flash_read_control

// ---- tb/flash_read_check_properties.sv ----
// port-level checker of the burst flash read controller
`timescale 1ns/1ps
module flash_read_check #(
    parameter int BADDR_BITS = 2
) (
    // clock, reset and processor side
    input wire logic                  CLK_IN, RST_B_IN,
    input wire logic                  ADDRESS_STROBE_B_IN,
    input wire logic                  WRITE_READ_SELECT_IN,
    input wire logic                  BACKOFF_REQUEST_B_IN, BURST_LAST_B_IN,
    input wire logic [BADDR_BITS-1:0] CPU_ADDR_IN,
    input wire logic                  FLASH_REGION_SELECT_IN, CONFIG_SELECT_IN,
    // outputs watched
    input wire logic                  BURST_READY_B_OUT,
    input wire logic                  CACHE_ENABLE_ACK_B_OUT,
    input wire logic                  FLASH_ADDRESS_VALID_B_OUT,
    input wire logic                  FLASH_OUTPUT_ENABLE_B_OUT,
    input wire logic                  FLASH_CHIP_ENABLE_B_OUT,
    input wire logic                  ADDRESS_PATH_SELECT_OUT,
    input wire logic [BADDR_BITS-1:0] BURST_ADDR_OUT
);
    wire idle = ADDRESS_PATH_SELECT_OUT; // only idle hands path to cpu
    wire adv_b = FLASH_ADDRESS_VALID_B_OUT;
    wire oe_b = FLASH_OUTPUT_ENABLE_B_OUT;
    wire ken_b = CACHE_ENABLE_ACK_B_OUT;
    wire rdy_b = BURST_READY_B_OUT;
    wire [BADDR_BITS-1:0] a = BURST_ADDR_OUT;
    wire [BADDR_BITS-1:0] s = CPU_ADDR_IN; // cpu holds it all burst
    wire run = !idle && BURST_LAST_B_IN && BACKOFF_REQUEST_B_IN;
    wire take = idle && !ADDRESS_STROBE_B_IN && !WRITE_READ_SELECT_IN
        && BACKOFF_REQUEST_B_IN && !FLASH_REGION_SELECT_IN;
    logic opt_q; // mode of the burst in flight, config held steady
    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) opt_q <= 1'b0;
        else if (take) opt_q <= CONFIG_SELECT_IN;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    // config is synchronised, so it must be steady for two edges
    sequence def_take_s;
        take && !CONFIG_SELECT_IN && !$past(CONFIG_SELECT_IN)
            && !$past(CONFIG_SELECT_IN, 2);
    endsequence
    sequence opt_take_s;
        take && CONFIG_SELECT_IN && $past(CONFIG_SELECT_IN)
            && $past(CONFIG_SELECT_IN, 2);
    endsequence
    sequence def_walk_s;
        (adv_b && !idle && a == (s ^ 2'h1)) ##1 !adv_b
        ##1 (adv_b && !oe_b && a == (s ^ 2'h2))
        ##1 (!adv_b && !ken_b && rdy_b)
        ##1 (adv_b && !rdy_b && a == (s ^ 2'h3));
    endsequence
    sequence opt_walk_s;
        (!adv_b && !idle && a == (s ^ 2'h1))
        ##1 (!oe_b && !ken_b && a == (s ^ 2'h2))
        ##1 (!rdy_b && a == (s ^ 2'h3)) ##1 adv_b;
    endsequence
    AST_DEF_WALK: assert property (
        def_take_s |=> def_walk_s)
        else $error("default burst walk wrong");
    AST_OPT_WALK: assert property (
        opt_take_s |=> opt_walk_s)
        else $error("optimized burst walk wrong");
    AST_ABORT: assert property (
        !BACKOFF_REQUEST_B_IN |=> idle && oe_b && rdy_b)
        else $error("backoff did not abort");
    AST_CHIP_EN: assert property (!FLASH_CHIP_ENABLE_B_OUT)
        else $error("chip enable dropped");
    AST_IDLE_HOLD: assert property (
        idle |-> !adv_b && oe_b && rdy_b && ken_b)
        else $error("idle outputs wrong");
    AST_RESET_VAL: assert property (
        $rose(RST_B_IN) |-> idle && a == 0)
        else $error("reset state wrong");
    AST_REFUSE: assert property (idle && !ADDRESS_STROBE_B_IN
        && (WRITE_READ_SELECT_IN || FLASH_REGION_SELECT_IN) |=> idle)
        else $error("refused cycle was taken");
    AST_END: assert property (
        !idle && !rdy_b && !BURST_LAST_B_IN
        |=> idle && oe_b && rdy_b && ken_b) else $error("burst did not end");
    AST_OPT_HOLD: assert property (opt_q && run && !rdy_b
        |=> !rdy_b && !oe_b && !ken_b) else $error("ready not held");
    AST_DEF_TOGGLE: assert property (!opt_q && run && !rdy_b
        |=> rdy_b ##1 !rdy_b) else $error("ready not toggling");
endmodule : flash_read_check
bind burst_flash_read_control flash_read_check #(.BADDR_BITS(BADDR_BITS))
    chk_u (.CLK_IN, .RST_B_IN, .ADDRESS_STROBE_B_IN, .WRITE_READ_SELECT_IN,
    .BACKOFF_REQUEST_B_IN, .BURST_LAST_B_IN, .CPU_ADDR_IN,
    .FLASH_REGION_SELECT_IN, .CONFIG_SELECT_IN, .BURST_READY_B_OUT,
    .CACHE_ENABLE_ACK_B_OUT, .FLASH_ADDRESS_VALID_B_OUT,
    .FLASH_OUTPUT_ENABLE_B_OUT, .FLASH_CHIP_ENABLE_B_OUT,
    .ADDRESS_PATH_SELECT_OUT, .BURST_ADDR_OUT);

// ---- tb/cpu_bus_model.sv ----
// processor side of the bus: opens cycles, takes words, marks the last
`timescale 1ns/1ps
module cpu_bus_model (
    // clock, reset and commands
    input  wire logic        clk_in, rst_b_in, start_in, write_in,
    input  wire logic [1:0]  addr_in,
    // bus toward the controller
    input  wire logic        burst_ready_b_in,
    output logic             ads_b_out, wr_out, burst_last_b_out,
    output logic [1:0]       a_out,
    // edges where ready was seen low, counted from the strobe edge
    output logic [15:0]      seen_out
);
    logic [3:0] edge_q;  // number of the coming edge
    logic [2:0] words_q; // words taken so far
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || start_in) begin
            ads_b_out <= !rst_b_in; // strobe for one clock only
            wr_out <= write_in;
            a_out <= addr_in; // address held through the burst
            burst_last_b_out <= 1'b1;
            seen_out <= 16'h0;
            edge_q <= 4'h1;
            words_q <= 3'h0;
        end else begin
            ads_b_out <= 1'b1;
            if (edge_q != 4'hf) edge_q <= edge_q + 4'h1;
            if (!burst_ready_b_in) begin
                seen_out[edge_q] <= 1'b1; // word latched here
                words_q <= words_q + 3'h1;
                burst_last_b_out <= (words_q != 3'h2); // last before word four
            end
        end
    end
endmodule : cpu_bus_model

// ---- tb/burst_flash_read_control_bench.sv ----
// self-checking bench of the burst flash read controller
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, (e), (a)); end end
module burst_flash_read_control_bench;
    import flash_read_pkg::*;
    logic clk = 0, rst_b = 0, backoff_request_b = 1, region = 0, cfg = 0;
    logic start = 0, wr_cmd = 0;
    logic [1:0] s_cmd = 0;
    wire ads_b, wr, burst_last_b, rdy_b, ken_b, adv_b, oe_b, ce_b, path;
    wire [1:0] cpu_a, baddr;
    wire [15:0] seen; // edges where the cpu took a word
    logic [3:0] n_acc = 0; // flash reads started after the first
    int n_fail = 0, n_checks = 0, cyc = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        // flash starts a read at every edge that sees valid low
        if (start) n_acc <= 4'h0;
        else if (!adv_b && !path) n_acc <= n_acc + 4'h1;
        if (cyc == 2000) begin
            n_fail++;
            give_verdict();
        end
    end
    burst_flash_read_control dut_u (.CLK_IN(clk), .RST_B_IN(rst_b),
        .ADDRESS_STROBE_B_IN(ads_b), .WRITE_READ_SELECT_IN(wr),
        .BACKOFF_REQUEST_B_IN(backoff_request_b), .BURST_LAST_B_IN(burst_last_b),
        .CPU_ADDR_IN(cpu_a), .FLASH_REGION_SELECT_IN(region),
        .CONFIG_SELECT_IN(cfg), .BURST_READY_B_OUT(rdy_b),
        .CACHE_ENABLE_ACK_B_OUT(ken_b), .FLASH_ADDRESS_VALID_B_OUT(adv_b),
        .FLASH_OUTPUT_ENABLE_B_OUT(oe_b), .FLASH_CHIP_ENABLE_B_OUT(ce_b),
        .ADDRESS_PATH_SELECT_OUT(path), .BURST_ADDR_OUT(baddr));
    cpu_bus_model cpu_u (.clk_in(clk), .rst_b_in(rst_b), .start_in(start),
        .write_in(wr_cmd), .addr_in(s_cmd), .burst_ready_b_in(rdy_b),
        .ads_b_out(ads_b), .wr_out(wr), .burst_last_b_out(burst_last_b),
        .a_out(cpu_a), .seen_out(seen));
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // config settles through its synchroniser before the strobe
    task go(input logic c, input logic w, input logic [1:0] s);
        tick(1);
        cfg <= c;
        tick(4);
        wr_cmd <= w;
        s_cmd <= s;
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
    endtask : go
    task t_burst(input logic c, input logic [1:0] s);
        go(c, 1'b0, s);
        tick(15);
        #1;
        `CHK("word edges", c ? 16'h00f0 : 16'h1540, seen)
        `CHK("idle after", 2'h3, {path, oe_b})
        `CHK("flash reads", 4'h3, n_acc)
    endtask : t_burst
    task t_refuse;
        for (int k = 0; k < 3; k++) begin
            tick(1);
            region <= (k == 1);
            backoff_request_b <= (k != 2);
            go(1'b0, k == 0, 2'h2);
            tick(10);
            #1;
            `CHK("refused words", 16'h0, seen)
            `CHK("refused path", 1'b1, path)
        end
        tick(1);
        region <= 1'b0;
        backoff_request_b <= 1'b1;
    endtask : t_refuse
    // abort after the walk each mode checks, in both modes
    task t_abort(input logic c);
        go(c, 1'b0, 2'h3);
        tick(c ? 4 : 5);
        backoff_request_b <= 1'b0;
        tick(1);
        backoff_request_b <= 1'b1;
        #1;
        `CHK("abort oe", 1'b1, oe_b)
        `CHK("abort idle", 1'b1, path)
        `CHK("abort words", c ? 16'h0030 : 16'h0040, seen)
    endtask : t_abort
    task give_verdict;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        #1;
        `CHK("reset hs", 3'h7, {rdy_b, ken_b, oe_b})
        `CHK("reset idle", 5'h04, {adv_b, ce_b, path, baddr})
        for (int c = 0; c < 2; c++) begin
            for (int s = 0; s < 4; s++) t_burst(c[0], s[1:0]);
        end
        t_refuse();
        t_abort(1'b1);
        t_abort(1'b0);
        t_burst(1'b1, 2'h3);
        give_verdict();
    end
endmodule : burst_flash_read_control_bench
